// ### rtl/sdac_consts.svh
`ifndef SDAC_CONSTS_SVH
`define SDAC_CONSTS_SVH
// ----------------------------------------
// Register byte addresses (APB, one word each)
// ----------------------------------------
`define SDAC_OFS_CTRL0 12'h000
`define SDAC_OFS_CTRL1 12'h004
`define SDAC_OFS_CLKSEL 12'h008
`define SDAC_OFS_RESL 12'h00c
`define SDAC_OFS_RESM 12'h010
`define SDAC_OFS_RESH 12'h014
`define SDAC_OFS_IRQ 12'h018
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SDAC_C1_MODE_LSB 5
`define SDAC_C1_NREF 4
`define SDAC_C1_PREF 3
`define SDAC_C1_HOLD 2
`define SDAC_C1_DONE 1
`define SDAC_C0_RST 7
`define SDAC_C0_SLP 6
`define SDAC_C0_OFF 5
`define SDAC_C0_RATE_LSB 2
`define SDAC_C0_REFS 0
`define SDAC_IRQ_GIE 0
`define SDAC_IRQ_CIE 1
`define SDAC_IRQ_FLAG 2
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define SDAC_CTRL0_RST 8'h20
`define SDAC_CTRL1_RST 8'h00
`define SDAC_CLKSEL_RST 5'h00
`define SDAC_CLK_BYPASS 5'h1f
`define SDAC_RES_MAX 20'h7ffff
`define SDAC_RES_MIN 20'h80000
`endif

// ### rtl/sdac_pkg.sv
`default_nettype none
package sdac_pkg;
  typedef enum logic [1:0] {
    SDAC_PWRDN, SDAC_SLEEP, SDAC_RESET, SDAC_RUN
  } sdac_mode_t;
  typedef struct packed {
    logic ampOn;
    logic convOn;
    logic filterRst;
  } sdac_power_t;
  typedef struct packed {
    logic valid;
    logic overRange;
    logic underRange;
    logic [19:0] value;
  } sdac_sample_t;
endpackage
`default_nettype wire

// ### rtl/sdac_clk_div.sv
`timescale 1ns/10ps
`default_nettype none
`include "sdac_consts.svh"
module sdac_clk_div (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Control
  input wire logic [4:0] conv_clock_divisor,
  // Converter clock enable tick
  output logic convTick
);
  import sdac_pkg::*;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [5:0] limit;
  logic bypass;
  // System clock / 2 / (field+1): tick every 2*(field+1) cycles, except code 1f, which ticks every cycle
  assign bypass = conv_clock_divisor == `SDAC_CLK_BYPASS;
  assign limit = {conv_clock_divisor, 1'b1};
  assign cnt_nxt = (cnt_r >= limit) ? 6'h00 : cnt_r + 6'h01;
  assign convTick = bypass | (cnt_r == 6'h00);
  // Divider counter
  always_ff @(posedge clock or posedge reset) begin
    if (reset) cnt_r <= 6'h00;
    else cnt_r <= cnt_nxt;
  end
endmodule
`default_nettype wire

// ### rtl/sdac_result_path.sv
`timescale 1ns/10ps
`default_nettype none
`include "sdac_consts.svh"
module sdac_result_path (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Sample in, hold control
  input wire sdac_pkg::sdac_sample_t sample,
  input wire logic holdEn,
  // Held result and accept pulse
  output logic [19:0] result,
  output logic accepted
);
  import sdac_pkg::*;
  logic [19:0] result_r;
  logic [19:0] sat;
  // Clamp out-of-range values to full scale
  assign sat = sample.overRange ? `SDAC_RES_MAX :
               sample.underRange ? `SDAC_RES_MIN : sample.value;
  // While held, newer results are discarded
  assign accepted = sample.valid & ~holdEn;
  assign result = result_r;
  // One 20-bit word updates all three bytes at once
  always_ff @(posedge clock or posedge reset) begin
    if (reset) result_r <= 20'h00000;
    else if (accepted) result_r <= sat;
  end
  a_hold_freeze: assert property (@(posedge clock) disable iff (reset)
    holdEn |=> $stable(result_r)) else $error("result changed in hold");
  a_sat_high: assert property (@(posedge clock) disable iff (reset)
    accepted && sample.overRange |=> result_r == `SDAC_RES_MAX)
    else $error("no positive clamp");
endmodule
`default_nettype wire

// ### rtl/sdac_ctrl.sv
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "sdac_consts.svh"
module sdac_ctrl (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Modulator side
  input wire sdac_pkg::sdac_sample_t sample,
  output sdac_pkg::sdac_power_t power,
  output logic convTick,
  output logic lowLatency,
  output logic clkDiv12,
  output logic [1:0] chopFactor,
  output logic [14:0] oversampleRatio,
  output logic neg_ref_buffer_en,
  output logic pos_ref_buffer_en,
  output logic reference_select,
  // Interrupt to processor
  output logic convIrq
);
  import sdac_pkg::*;
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] ctrl0_r;
  logic [7:0] ctrl1_r;
  logic [4:0] clkSel_r;
  logic [1:0] irqEn_r;
  logic done_r;
  logic irqFlag_r;
  logic rstPrev_r;
  logic [19:0] result;
  logic accepted;
  sdac_mode_t mode;
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic access;
  logic wrEn;
  logic known;
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = a == o;
  endfunction
  assign access = psel & penable;
  assign wrEn = access & pwrite;
  assign pready = 1'b1; // Zero wait states
  assign known = hit(paddr, `SDAC_OFS_CTRL0) | hit(paddr, `SDAC_OFS_CTRL1) |
                 hit(paddr, `SDAC_OFS_CLKSEL) | hit(paddr, `SDAC_OFS_RESL) |
                 hit(paddr, `SDAC_OFS_RESM) | hit(paddr, `SDAC_OFS_RESH) |
                 hit(paddr, `SDAC_OFS_IRQ);
  assign pslverr = access & ~known;
  logic wrC0;
  logic wrC1;
  logic wrCs;
  logic wrIrq;
  assign wrC0 = wrEn & hit(paddr, `SDAC_OFS_CTRL0);
  assign wrC1 = wrEn & hit(paddr, `SDAC_OFS_CTRL1);
  assign wrCs = wrEn & hit(paddr, `SDAC_OFS_CLKSEL);
  assign wrIrq = wrEn & hit(paddr, `SDAC_OFS_IRQ);
  // Read mux; unimplemented bits return zero
  logic [7:0] rdByte;
  assign rdByte =
    hit(paddr, `SDAC_OFS_CTRL0) ? {ctrl0_r[7:2], 1'b0, ctrl0_r[0]} :
    hit(paddr, `SDAC_OFS_CTRL1) ? {ctrl1_r[7:2], done_r, 1'b0} :
    hit(paddr, `SDAC_OFS_CLKSEL) ? {3'h0, clkSel_r} :
    hit(paddr, `SDAC_OFS_RESL) ? result[7:0] :
    hit(paddr, `SDAC_OFS_RESM) ? result[15:8] :
    hit(paddr, `SDAC_OFS_RESH) ? {4'h0, result[19:16]} :
    hit(paddr, `SDAC_OFS_IRQ) ? {5'h00, irqFlag_r, irqEn_r} : 8'h00;
  // High byte sign-extended into bits above would mislead; keep upper 24 bits low
  always_ff @(posedge clock or posedge reset) begin
    if (reset) prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite) prdata <= {24'h000000, rdByte};
  end
  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // Power off beats sleep beats restart
  assign mode = ctrl0_r[`SDAC_C0_OFF] ? SDAC_PWRDN :
                ctrl0_r[`SDAC_C0_SLP] ? SDAC_SLEEP :
                ctrl0_r[`SDAC_C0_RST] ? SDAC_RESET : SDAC_RUN;
  always_comb begin
    power = '0;
    case (mode)
      SDAC_PWRDN: power = '0;
      SDAC_SLEEP: power.ampOn = 1'b1;
      SDAC_RESET: power = 3'b111;
      SDAC_RUN: power = 3'b110;
      default: power = '0;
    endcase
  end
  // Restart falling edge: filter leaves reset, new conversion starts
  logic restartDone;
  assign restartDone = rstPrev_r & ~ctrl0_r[`SDAC_C0_RST];
  // ----------------------------------------
  // Output configuration
  // ----------------------------------------
  // Codes 000/010/100/110 valid; others reserved, bit 5 ignored so each acts as the even code below
  assign lowLatency = ctrl1_r[7];
  assign clkDiv12 = ctrl1_r[6];
  assign chopFactor = lowLatency ? 2'h1 : 2'h2;
  assign oversampleRatio = 15'h4000 >> ctrl0_r[4:2];
  assign neg_ref_buffer_en = ctrl1_r[`SDAC_C1_NREF];
  assign pos_ref_buffer_en = ctrl1_r[`SDAC_C1_PREF];
  assign reference_select = ctrl0_r[`SDAC_C0_REFS];
  // ----------------------------------------
  // Result path and divider
  // ----------------------------------------
  sdac_clk_div uDiv (
    .clock(clock),
    .reset(reset),
    .conv_clock_divisor(clkSel_r),
    .convTick(convTick)
  );
  sdac_result_path uRes (
    .clock(clock),
    .reset(reset),
    .sample(sample),
    .holdEn(ctrl1_r[`SDAC_C1_HOLD]),
    .result(result),
    .accepted(accepted)
  );
  // ----------------------------------------
  // Done flag and interrupt request
  // ----------------------------------------
  // Set only on accepted conversions; set beats software clear
  logic clrDone;
  logic clrFlag;
  assign clrDone = wrC1 & ~pwdata[`SDAC_C1_DONE];
  assign clrFlag = wrIrq & ~pwdata[`SDAC_IRQ_FLAG];
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      done_r <= 1'b0;
      irqFlag_r <= 1'b0;
    end else begin
      done_r <= accepted | (done_r & ~clrDone);
      irqFlag_r <= accepted | (irqFlag_r & ~clrFlag);
    end
  end
  // Both enables needed to reach the core
  assign convIrq = irqFlag_r & irqEn_r[`SDAC_IRQ_GIE] & irqEn_r[`SDAC_IRQ_CIE];
  // ----------------------------------------
  // Control register writes
  // ----------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl0_r <= `SDAC_CTRL0_RST;
      ctrl1_r <= `SDAC_CTRL1_RST;
      clkSel_r <= `SDAC_CLKSEL_RST;
      irqEn_r <= 2'h0;
      rstPrev_r <= 1'b0;
    end else begin
      rstPrev_r <= ctrl0_r[`SDAC_C0_RST];
      if (wrC0) ctrl0_r <= {pwdata[7:2], 1'b0, pwdata[0]};
      if (wrC1) ctrl1_r <= {pwdata[7:2], 2'b00};
      if (wrCs) clkSel_r <= pwdata[4:0];
      if (wrIrq) irqEn_r <= pwdata[1:0];
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_accept;
    accepted;
  endsequence
  a_done_sets: assert property (@(posedge clock) disable iff (reset)
    s_accept |=> done_r && irqFlag_r) else $error("done not set");
  a_done_sticky: assert property (@(posedge clock) disable iff (reset)
    done_r && !clrDone |=> done_r) else $error("done self-cleared");
  a_hold_quiet: assert property (@(posedge clock) disable iff (reset)
    ctrl1_r[`SDAC_C1_HOLD] && !done_r && !wrC1 |=> !done_r)
    else $error("done set during hold");
  a_irq_gate: assert property (@(posedge clock) disable iff (reset)
    convIrq |-> irqEn_r == 2'h3 && irqFlag_r) else $error("irq gate");
  a_mode_prio: assert property (@(posedge clock) disable iff (reset)
    ctrl0_r[`SDAC_C0_OFF] |-> !power.ampOn && !power.convOn)
    else $error("power off ignored");
  a_zero_bits: assert property (@(posedge clock) disable iff (reset)
    access && !pwrite && hit(paddr, `SDAC_OFS_CLKSEL)
    |-> prdata[7:5] == 3'h0)
    else $error("nonzero reserved");
  a_restart_seen: assert property (@(posedge clock) disable iff (reset)
    restartDone && mode == SDAC_RUN |-> power.convOn && !power.filterRst)
    else $error("restart edge");
  a_ref_bufs: assert property (@(posedge clock) disable iff (reset)
    wrC1 |=> pos_ref_buffer_en == $past(pwdata[3]))
    else $error("buffer enable");
endmodule
`default_nettype wire

// ### bench/sdac_mod_model.sv
`timescale 1ns/10ps
`default_nettype none
module sdac_mod_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Power state from the control block
  input wire sdac_pkg::sdac_power_t power,
  // Finished conversions
  output var sdac_pkg::sdac_sample_t sample
);
  import sdac_pkg::*;
  // ----------------------------------------
  // Conversion emitter
  // ----------------------------------------
  initial sample = '0;
  // One-cycle result pulse; value inverted after so stale data never matches
  task automatic emit(input logic [19:0] v, input logic ov, input logic un);
    @(posedge clock);
    if (power.convOn && !reset) begin
      sample <= '{1'b1, ov, un, v};
      @(posedge clock);
      sample <= '{1'b0, 1'b0, 1'b0, ~v};
    end
  endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "sdac_consts.svh"
module tb;
  import sdac_pkg::*;
  logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic pready, pslverr, convTick, lowLatency, clkDiv12, convIrq, perr;
  logic neg_ref_buffer_en, pos_ref_buffer_en, reference_select;
  logic [1:0] chopFactor;
  logic [14:0] oversampleRatio;
  sdac_sample_t sample;
  sdac_power_t power;
  int n_errors = 0, samples_checked = 0, ticks;
  logic [7:0] c0v [6] = '{8'h20, 8'h60, 8'h40, 8'hc0, 8'h80, 8'h00};
  logic [2:0] pw [6] = '{3'b000, 3'b000, 3'b100, 3'b100, 3'b111, 3'b110};
  sdac_ctrl i_sdac_ctrl (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample(sample),
    .power(power), .convTick(convTick), .lowLatency(lowLatency),
    .clkDiv12(clkDiv12), .chopFactor(chopFactor),
    .oversampleRatio(oversampleRatio),
    .neg_ref_buffer_en(neg_ref_buffer_en),
    .pos_ref_buffer_en(pos_ref_buffer_en),
    .reference_select(reference_select), .convIrq(convIrq));
  sdac_mod_model i_sdac_mod_model (.clock(clock), .reset(reset),
    .power(power), .sample(sample));
  // ----------------------------------------
  // Clock and bus tasks
  // ----------------------------------------
  always #10 clock = ~clock;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", nm, e, g);
      n_errors++;
    end
  endtask
  // Setup, then access held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rdat = prdata;
    perr = pslverr;
    psel <= 0; penable <= 0;
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), {24'h0, e}, rdat);
  endtask
  // Count converter ticks over 60 system cycles
  task automatic cnt();
    ticks = 0;
    repeat (60) begin
      @(posedge clock);
      #1;
      if (convTick === 1'b1) ticks++;
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    reset <= 0;
    rd(`SDAC_OFS_CTRL0, 8'h20);
    chk("pready", 1, 32'(pready));
    rd(`SDAC_OFS_CTRL1, 8'h00);
    wr(`SDAC_OFS_CLKSEL, 8'hff);
    rd(`SDAC_OFS_CLKSEL, 8'h1f);
    cnt();
    chk("bypass ticks", 60, ticks);
    wr(`SDAC_OFS_CLKSEL, 8'h02);
    cnt();
    chk("div ticks", 10, ticks);
    wr(`SDAC_OFS_CTRL1, 8'hff);
    rd(`SDAC_OFS_CTRL1, 8'hfc);
    chk("refbuf", 2'b11, {neg_ref_buffer_en, pos_ref_buffer_en});
    wr(`SDAC_OFS_CTRL1, 8'h08);
    chk("refbuf", 2'b01, {neg_ref_buffer_en, pos_ref_buffer_en});
    for (int m = 0; m < 8; m += 2) begin
      wr(`SDAC_OFS_CTRL1, 8'(m << 5));
      chk("mode", 32'(m >> 1), {lowLatency, clkDiv12});
    end
    for (int i = 0; i < 6; i++) begin
      wr(`SDAC_OFS_CTRL0, c0v[i]);
      chk("power", 32'(pw[i]), 32'(power));
    end
    for (int r = 0; r < 8; r++) begin
      wr(`SDAC_OFS_CTRL0, 8'(r << 2));
      chk("osr", 32'(16384 >> r), 32'(oversampleRatio));
    end
    chk("chop", 1, 32'(chopFactor));
    wr(`SDAC_OFS_CTRL1, 8'h00);
    chk("chop", 2, 32'(chopFactor));
    wr(`SDAC_OFS_CTRL0, 8'h01);
    chk("refsel", 1, 32'(reference_select));
    wr(`SDAC_OFS_CTRL0, 8'h00);
    wr(`SDAC_OFS_IRQ, 8'h03);
    i_sdac_mod_model.emit(20'h12345, 1'b0, 1'b0);
    rd(`SDAC_OFS_RESL, 8'h45);
    rd(`SDAC_OFS_RESM, 8'h23);
    rd(`SDAC_OFS_RESH, 8'h01);
    rd(`SDAC_OFS_CTRL1, 8'h02);
    rd(`SDAC_OFS_IRQ, 8'h07);
    chk("irq", 1, 32'(convIrq));
    wr(`SDAC_OFS_CTRL1, 8'h00);
    rd(`SDAC_OFS_CTRL1, 8'h00);
    wr(`SDAC_OFS_IRQ, 8'h02);
    i_sdac_mod_model.emit(20'h80001, 1'b0, 1'b0);
    rd(`SDAC_OFS_IRQ, 8'h06);
    chk("irq", 0, 32'(convIrq));
    rd(`SDAC_OFS_RESH, 8'h08);
    wr(`SDAC_OFS_IRQ, 8'h03);
    wr(`SDAC_OFS_CTRL1, 8'h04);
    i_sdac_mod_model.emit(20'h00055, 1'b0, 1'b0);
    rd(`SDAC_OFS_RESL, 8'h01);
    rd(`SDAC_OFS_CTRL1, 8'h04);
    rd(`SDAC_OFS_IRQ, 8'h03);
    wr(`SDAC_OFS_CTRL1, 8'h00);
    i_sdac_mod_model.emit(20'h00000, 1'b1, 1'b0);
    rd(`SDAC_OFS_RESH, 8'h07);
    rd(`SDAC_OFS_RESL, 8'hff);
    i_sdac_mod_model.emit(20'h00000, 1'b0, 1'b1);
    rd(`SDAC_OFS_RESH, 8'h08);
    // Mid-run reset must bring back power-off, clear result and request
    @(posedge clock) reset <= 1;
    repeat (2) @(posedge clock);
    reset <= 0;
    rd(`SDAC_OFS_CTRL0, 8'h20);
    rd(`SDAC_OFS_RESH, 8'h00);
    chk("irq", 0, 32'(convIrq));
    apb(1'b0, 12'h01c, 32'h0);
    chk("slverr", 1, 32'(perr));
    chk("unmapped", 0, rdat);
    report_and_stop();
  end
endmodule
`default_nettype wire
